// *** core/sfs_defines.vh ***
`ifndef SFS_DEFINES_VH
`define SFS_DEFINES_VH
// Command codes
`define SFS_CMD_FAULT_ACTION  8'h63
`define SFS_CMD_OFF_DELAY     8'h64
`define SFS_CMD_FALL_TIME     8'h65
`define SFS_CMD_SUMMARY       8'h78
`define SFS_CMD_STATUS_WORD   8'h79
// Fault action fields
`define SFS_ACT_HI            7
`define SFS_ACT_LO            6
`define SFS_RETRY_HI          5
`define SFS_RETRY_LO          3
`define SFS_DLY_HI            2
`define SFS_DLY_LO            0
`define SFS_ACT_IGNORE        2'h0
`define SFS_ACT_DELAYED       2'h1
`define SFS_ACT_IMMEDIATE     2'h2
`define SFS_RETRY_FOREVER     3'h7
// Linear-11 layout
`define SFS_EXP_HI            15
`define SFS_EXP_LO            11
`define SFS_MAN_HI            10
`define SFS_MAN_LO            0
// Reset values
`define SFS_FAULT_ACTION_RST  8'h00
`define SFS_OFF_DELAY_RST     16'hF800
`define SFS_FALL_TIME_RST     16'hF002
`define SFS_OFF_EXP           5'h1F
`define SFS_FALL_EXP          5'h1E
// Range limits, in mantissa steps
`define SFS_OFF_MAN_MAX       11'h0FF
`define SFS_FALL_MAN_MAX      11'h07F
`define SFS_FALL_MAN_MIN      11'h002
// Summary bits
`define SFS_SUM_OFF           6
`define SFS_SUM_OV            5
`define SFS_SUM_CML           1
`define SFS_SUM_NOTA          0
// Timing
`define SFS_CLK_HZ            20000000
`define SFS_MS_NS             1000000
`define SFS_CLK_NS            50
`define SFS_MS_CYC            (`SFS_MS_NS / `SFS_CLK_NS)
`define SFS_QMS_CYC           (`SFS_MS_CYC / 4)
`define SFS_INT_DLY_US        50
`define SFS_INT_DLY_CYC       ((`SFS_INT_DLY_US * 1000) / `SFS_CLK_NS)
`define SFS_START_PCT         85
`endif

// *** core/sfs_startup_fault_softoff.v ***
// Contract
// - Action code 00 ignores start timeout, conversion continues.
// - Code 01 runs for shutdown delay, then shuts down if fault persists.
// - Code 10 shuts down at once, then follows restart policy.
// - Fault action writes with code 11 are rejected as invalid data.
// - Restart count 0 latches off, no restart.
// - Counts 1..6 wait one restart period, retry at most that many times; recovery or stop in the code 01 delay keeps the count, adding retries later.
// - Count 7 retries forever until off command or good start.
// - Delay field 0 means 1 ms shutdown delay, period of one rise time.
// - Delay n gives n ms delay; period n+1... capped at seven rise times.
// - After stop, energy delivered for the turn-off delay.
// - Turn-off delay linear-11, exponent 11111, 0 to 127.5 ms.
// - Internal delay up to 50 us added, even for zero.
// - Out of range delay or fall writes are invalid data.
// - After delay, reference ramps to zero over the fall time.
// - Ramp slope gives the programmed fall time at high setpoints; low setpoints reach zero sooner.
// - Fall time exponent -2, 0.25 ms steps up to 31.75 ms.
// - Fall times under 0.5 ms run as 0.5 ms.
// - Slope quantisation may merge fall settings at low setpoints.
// - Summary byte always equals status word low byte.
// - Summary bits 5..2 follow detailed status; bits 1 and 0 also hold sticky CML and timeout flags, bit 6 is off state.
// - Timeout sets summary, word output bit, timeout bit, alerts host.
// - Timeout when output below 85 percent after limit time.
// - Rise time runs from output rising to regulation band.
`include "sfs_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module sfs_startup_fault_softoff
#(
  parameter        REF_W        = 16,
  parameter [31:0] MS_CYC       = `SFS_MS_CYC,
  parameter [31:0] INT_DLY_CYC  = `SFS_INT_DLY_CYC
)
(
  input  wire             sys_clk_i,
  input  wire             rst_n_i,
  input  wire             wr_stb_i,
  input  wire             rd_stb_i,
  input  wire [7:0]       cmd_i,
  input  wire [15:0]      wr_data_i,
  output reg  [15:0]      rd_data_o,
  output reg              alert_o,
  input  wire             alert_clr_i,
  input  wire             run_cmd_i,
  input  wire [REF_W-1:0] vout_target_i,
  input  wire [REF_W-1:0] vout_sense_i,
  input  wire             tmax_enable_i,
  input  wire [15:0]      tmax_limit_qms_i,
  input  wire [15:0]      rise_qms_i,
  input  wire             vout_in_band_i,
  input  wire [7:0]       detail_vout_i,
  input  wire             detail_output_overvoltage_summary_i,
  input  wire [4:0]       detail_other_sum_i,
  output reg              timeout_event_o,
  output reg              convert_o,
  output reg  [REF_W-1:0] ref_dac_o,
  output reg              cml_event_o
);

  ////////////////////////////////////////////////////////////////
  // States
  localparam [6:0] ST_OFF   = 7'h01;
  localparam [6:0] ST_DELAY = 7'h02;
  localparam [6:0] ST_RISE  = 7'h04;
  localparam [6:0] ST_ON    = 7'h08;
  localparam [6:0] ST_GRACE = 7'h10;
  localparam [6:0] ST_HICC  = 7'h20;
  localparam [6:0] ST_STOP  = 7'h40;

  reg  [6:0]       state_reg;
  reg  [7:0]       action_reg;
  reg  [15:0]      off_delay_reg;
  reg  [15:0]      fall_reg;
  reg  [2:0]       retries_reg;
  reg              latched_reg;
  reg              tmo_flag_reg;
  reg              cml_flag_reg;
  reg  [31:0]      tick_reg;
  reg  [31:0]      cnt_reg;
  reg  [15:0]      ref_step_reg;
  reg  [REF_W-1:0] ref_reg;
  reg              in_fall_reg;

  wire [1:0]  act_code    = action_reg[`SFS_ACT_HI:`SFS_ACT_LO];
  wire [2:0]  retry_field = action_reg[`SFS_RETRY_HI:`SFS_RETRY_LO];
  wire [2:0]  dly_field   = action_reg[`SFS_DLY_HI:`SFS_DLY_LO];
  wire [10:0] off_man     = off_delay_reg[`SFS_MAN_HI:`SFS_MAN_LO];
  wire [10:0] fall_man    = fall_reg[`SFS_MAN_HI:`SFS_MAN_LO];

  ////////////////////////////////////////////////////////////////
  // Write checks
  // valid code check
  wire act_ok  = (wr_data_i[`SFS_ACT_HI:`SFS_ACT_LO] != 2'h3);
  wire off_ok  = (wr_data_i[`SFS_EXP_HI:`SFS_EXP_LO] == `SFS_OFF_EXP) &&
                 (wr_data_i[`SFS_MAN_HI:`SFS_MAN_LO] <= `SFS_OFF_MAN_MAX);
  wire fall_ok = (wr_data_i[`SFS_EXP_HI:`SFS_EXP_LO] == `SFS_FALL_EXP) &&
                 (wr_data_i[`SFS_MAN_HI:`SFS_MAN_LO] <= `SFS_FALL_MAN_MAX);
  wire wr_act  = wr_stb_i && (cmd_i == `SFS_CMD_FAULT_ACTION);
  wire wr_off  = wr_stb_i && (cmd_i == `SFS_CMD_OFF_DELAY);
  wire wr_fall = wr_stb_i && (cmd_i == `SFS_CMD_FALL_TIME);
  wire bad_wr  = (wr_act && !act_ok) || (wr_off && !off_ok) || (wr_fall && !fall_ok);

  ////////////////////////////////////////////////////////////////
  // Derived times
  // delay and period in units
  wire [3:0]  dly_ms    = (dly_field == 3'h0) ? 4'h1 : {1'b0, dly_field};
  wire [3:0]  hicc_mult = (dly_field == 3'h0) ? 4'h1 :
                          (dly_field == 3'h7) ? 4'h7 : {1'b0, dly_field} + 4'h1;
  wire [31:0] dly_cyc   = MS_CYC * {28'h0, dly_ms};
  wire [31:0] hicc_cyc  = (MS_CYC >> 2) * {28'h0, hicc_mult} * {16'h0, rise_qms_i};
  wire [31:0] tmax_cyc  = (MS_CYC >> 2) * {16'h0, tmax_limit_qms_i};
  wire [31:0] off_cyc   = (MS_CYC >> 1) * {21'h0, off_man} + INT_DLY_CYC;
  wire [10:0] fall_eff  = (fall_man < `SFS_FALL_MAN_MIN) ? `SFS_FALL_MAN_MIN : fall_man;
  wire [31:0] fall_cyc  = (MS_CYC >> 2) * {21'h0, fall_eff};
  localparam [6:0] START_PCT = `SFS_START_PCT;
  wire [REF_W+6:0] sense_x = {7'h0, vout_sense_i} * 7'd100;
  wire [REF_W+6:0] targ_x  = {7'h0, vout_target_i} * START_PCT;
  wire        reached   = sense_x >= targ_x;
  wire        tmo_now   = tmax_enable_i && (state_reg == ST_RISE) &&
                          (cnt_reg >= tmax_cyc) && !reached;

  ////////////////////////////////////////////////////////////////
  // Command registers
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      action_reg    <= `SFS_FAULT_ACTION_RST;
      off_delay_reg <= `SFS_OFF_DELAY_RST;
      fall_reg      <= `SFS_FALL_TIME_RST;
    end
    else
    begin
      if (wr_act && act_ok)
        action_reg <= wr_data_i[7:0];
      if (wr_off && off_ok)
        off_delay_reg <= wr_data_i;
      if (wr_fall && fall_ok)
        fall_reg <= wr_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sticky flags; set beats clear
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tmo_flag_reg <= 1'b0;
      cml_flag_reg <= 1'b0;
      alert_o      <= 1'b0;
    end
    else
    begin
      tmo_flag_reg <= tmo_now | (tmo_flag_reg & ~alert_clr_i);
      cml_flag_reg <= bad_wr | (cml_flag_reg & ~alert_clr_i);
      alert_o      <= tmo_now | bad_wr | (alert_o & ~alert_clr_i);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg    <= ST_OFF;
      cnt_reg      <= 32'h0;
      retries_reg  <= 3'h0;
      latched_reg  <= 1'b0;
      convert_o    <= 1'b0;
      in_fall_reg  <= 1'b0;
      timeout_event_o <= 1'b0;
    end
    else
    begin
      timeout_event_o <= tmo_now;
      cnt_reg <= cnt_reg + 32'h1;
      case (state_reg)
        ST_OFF:
        begin
          convert_o   <= 1'b0;
          in_fall_reg <= 1'b0;
          if (!run_cmd_i)
            latched_reg <= 1'b0;
          else if (!latched_reg)
          begin
            state_reg <= ST_RISE;
            cnt_reg   <= 32'h0;
            convert_o <= 1'b1;
          end
        end
        ST_RISE:
        begin
          if (!run_cmd_i)
          begin
            state_reg <= ST_STOP;
            cnt_reg   <= 32'h0;
            retries_reg <= 3'h0;
          end
          else if (vout_in_band_i && reached)
          begin
            state_reg   <= ST_ON;
            retries_reg <= 3'h0;
          end
          else if (tmo_now)
          begin
            case (act_code)
              `SFS_ACT_IGNORE:  state_reg <= ST_ON;
              `SFS_ACT_DELAYED:
              begin
                state_reg <= ST_GRACE;
                cnt_reg   <= 32'h0;
              end
              default:
              begin
                state_reg <= ST_DELAY;
                cnt_reg   <= 32'h0;
                convert_o <= 1'b0;
              end
            endcase
          end
        end
        ST_GRACE:
        begin
          if (!run_cmd_i)
          begin
            state_reg <= ST_STOP;
            cnt_reg   <= 32'h0;
          end
          else if (reached)
            state_reg <= ST_ON;
          else if (cnt_reg >= dly_cyc)
          begin
            state_reg <= ST_DELAY;
            cnt_reg   <= 32'h0;
            convert_o <= 1'b0;
          end
        end
        ST_DELAY:
        begin
          // Shutdown point: pick restart policy
          cnt_reg <= 32'h0;
          if (!run_cmd_i)
            state_reg <= ST_OFF;
          else if (retry_field == 3'h0)
          begin
            latched_reg <= 1'b1;
            state_reg   <= ST_OFF;
          end
          else if (retries_reg == 3'h0 && !in_fall_reg)
          begin
            retries_reg <= retry_field;
            in_fall_reg <= 1'b1;
            state_reg   <= ST_HICC;
          end
          else if (retries_reg == 3'h0)
          begin
            latched_reg <= 1'b1;
            in_fall_reg <= 1'b0;
            state_reg   <= ST_OFF;
          end
          else
            state_reg <= ST_HICC;
        end
        ST_HICC:
        begin
          if (!run_cmd_i)
          begin
            state_reg   <= ST_OFF;
            retries_reg <= 3'h0;
          end
          else if (cnt_reg >= hicc_cyc)
          begin
            if (retry_field != `SFS_RETRY_FOREVER)
              retries_reg <= retries_reg - 3'h1;
            state_reg <= ST_RISE;
            cnt_reg   <= 32'h0;
            convert_o <= 1'b1;
          end
        end
        ST_ON:
        begin
          in_fall_reg <= 1'b0;
          if (!run_cmd_i)
          begin
            state_reg <= ST_STOP;
            cnt_reg   <= 32'h0;
          end
        end
        ST_STOP:
        begin
          if (cnt_reg >= off_cyc + fall_cyc)
          begin
            state_reg <= ST_OFF;
            convert_o <= 1'b0;
          end
        end
        default:
          state_reg <= ST_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Reference ramp
  // step per quarter ms, truncated slope plus one
  wire [15:0] step_calc = (vout_target_i / {5'h0, fall_eff[10:0]}) + 16'h1;
  wire        ramp_tick = (tick_reg >= (MS_CYC >> 2) - 32'h1);
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_reg     <= 32'h0;
      ref_step_reg <= 16'h0;
      ref_reg      <= {REF_W{1'b0}};
      ref_dac_o    <= {REF_W{1'b0}};
    end
    else
    begin
      tick_reg <= ramp_tick ? 32'h0 : tick_reg + 32'h1;
      if (state_reg == ST_RISE || state_reg == ST_ON || state_reg == ST_GRACE)
      begin
        ref_reg      <= vout_target_i;
        ref_step_reg <= step_calc;
      end
      // ramp down after the turn-off delay
      else if (state_reg == ST_STOP && cnt_reg >= off_cyc && ramp_tick)
        ref_reg <= (ref_reg > ref_step_reg[REF_W-1:0]) ? ref_reg - ref_step_reg[REF_W-1:0]
                                                       : {REF_W{1'b0}};
      else if (state_reg == ST_OFF || state_reg == ST_DELAY || state_reg == ST_HICC)
        ref_reg <= {REF_W{1'b0}};
      ref_dac_o <= ref_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Summary byte and read mux
  // summary built from detail, sticky CML and timeout flags, and convert state
  wire [7:0] summary;
  assign summary[7]            = 1'b0;
  assign summary[`SFS_SUM_OFF] = ~convert_o;
  assign summary[`SFS_SUM_OV]  = detail_output_overvoltage_summary_i;
  assign summary[4:2]          = detail_other_sum_i[4:2];
  assign summary[`SFS_SUM_CML] = cml_flag_reg | detail_other_sum_i[1];
  assign summary[`SFS_SUM_NOTA] = tmo_flag_reg | detail_other_sum_i[0];
  wire vout_word = tmo_flag_reg | (|detail_vout_i);

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o   <= 16'h0;
      cml_event_o <= 1'b0;
    end
    else
    begin
      cml_event_o <= bad_wr;
      if (rd_stb_i)
      begin
        if (cmd_i == `SFS_CMD_FAULT_ACTION)
          rd_data_o <= {8'h0, action_reg};
        else if (cmd_i == `SFS_CMD_OFF_DELAY)
          rd_data_o <= off_delay_reg;
        else if (cmd_i == `SFS_CMD_FALL_TIME)
          rd_data_o <= fall_reg;
        else if (cmd_i == `SFS_CMD_SUMMARY)
          rd_data_o <= {8'h0, summary};
        else if (cmd_i == `SFS_CMD_STATUS_WORD)
          rd_data_o <= {vout_word, 7'h0, summary};
        else
          rd_data_o <= 16'h0;
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/sfs_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfs_chk
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        wr_stb_i,
  input wire logic        rd_stb_i,
  input wire logic [7:0]  cmd_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [15:0] rd_data_o,
  input wire logic        alert_o,
  input wire logic        run_cmd_i,
  input wire logic        timeout_event_o,
  input wire logic        convert_o,
  input wire logic        cml_event_o
);
  logic [1:0] act_reg;
  ////////////////////////////////////////////////////////////
  // Shadow of the accepted action code, refused codes skipped
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      act_reg <= 2'h0;
    else if (wr_stb_i && cmd_i == 8'h63 && wr_data_i[7:6] != 2'h3)
      act_reg <= wr_data_i[7:6];
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_bad_action:
    assert property (wr_stb_i && cmd_i == 8'h63 && wr_data_i[7:6] == 2'h3 |=> cml_event_o && alert_o)
    else $error("refused action code not flagged");
  chk_delay_range:
    assert property (wr_stb_i && cmd_i == 8'h64 && (wr_data_i[15:11] != 5'h1F || wr_data_i[10:0] > 11'h0FF)
      |=> cml_event_o) else $error("bad off delay not flagged");
  chk_fall_range:
    assert property (wr_stb_i && cmd_i == 8'h65 && (wr_data_i[15:11] != 5'h1E || wr_data_i[10:0] > 11'h07F)
      |=> cml_event_o) else $error("bad fall time not flagged");
  chk_good_delay:
    assert property (wr_stb_i && cmd_i == 8'h64 && wr_data_i[15:8] == 8'hF8 |=> !cml_event_o)
    else $error("valid off delay flagged");
  chk_cml_alert:
    assert property (cml_event_o |-> alert_o) else $error("invalid write without alert");
  chk_timeout_alert:
    assert property (timeout_event_o |-> ##[0:1] alert_o ##1 !timeout_event_o) else $error("timeout not reported");
  chk_ignore_runs:
    assert property (timeout_event_o && act_reg == 2'h0 && run_cmd_i |=> convert_o [*4])
    else $error("ignored timeout stopped output");
  chk_delayed_runs:
    assert property (timeout_event_o && act_reg == 2'h1 |-> convert_o [*6]) else $error("delayed shutdown too early");
  chk_immediate_off:
    assert property (timeout_event_o && act_reg == 2'h2 |-> ##[0:2] !convert_o) else $error("no immediate shutdown");
  chk_stop_hold:
    assert property ($fell(run_cmd_i) && convert_o |=> convert_o [*3]) else $error("output stopped without delay");
  chk_action_read:
    assert property (rd_stb_i && cmd_i == 8'h63 |=> rd_data_o[7:6] != 2'h3 && rd_data_o[15:8] == 8'h00)
    else $error("action read back malformed");
endmodule
bind sfs_startup_fault_softoff sfs_chk u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wr_stb_i(wr_stb_i),
  .rd_stb_i(rd_stb_i), .cmd_i(cmd_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .alert_o(alert_o),
  .run_cmd_i(run_cmd_i), .timeout_event_o(timeout_event_o), .convert_o(convert_o), .cml_event_o(cml_event_o));
`default_nettype wire

// *** tb/sfs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfs_host_model
(
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] rd_data_i,
  output var  logic        wr_stb_o,
  output var  logic        rd_stb_o,
  output var  logic [7:0]  cmd_o,
  output var  logic [15:0] wr_data_o,
  output var  logic        alert_clr_o
);
  logic [15:0] last_q;
  initial
  begin
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    cmd_o = 8'h00;
    wr_data_o = 16'h0000;
    alert_clr_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // One command cycle; idle lines are inverted so stale data never looks valid
  task automatic put(input logic [7:0] c, input logic [15:0] d, input logic rd);
    @(negedge sys_clk_i);
    cmd_o = c;
    wr_data_o = d;
    wr_stb_o = !rd;
    rd_stb_o = rd;
    @(negedge sys_clk_i);
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    cmd_o = ~c;
    wr_data_o = ~d;
    last_q = rd_data_i;
  endtask
  // Acknowledge the alert
  task automatic clr;
    @(negedge sys_clk_i);
    alert_clr_o = 1'b1;
    @(negedge sys_clk_i);
    alert_clr_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/test_startup_fault_and_softoff_timing.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_startup_fault_and_softoff_timing;
  logic        sys_clk, rst_n, wr_stb, rd_stb, alert, alert_clr, run, tmax_en, dov, tev, conv, cml, ok, p;
  logic [7:0]  cmd, dvout, a;
  logic [15:0] wr_data, rd_data, vtgt, dac, d, q, vsense;
  logic        inband;
  logic [4:0]  dother;
  logic [23:0] cd;
  logic [31:0] r;
  logic [15:0] shadow[4];
  logic [23:0] corner[4] = '{24'h6300C0, 24'h64F900, 24'h65F080, 24'h65E802};
  logic [7:0]  acts[6] = '{8'h00, 8'h40, 8'h80, 8'h90, 8'hB0, 8'hB8};
  int          bad_count, samples_checked, cyc, rises, i, k, n, m, e;
  sfs_host_model host (.sys_clk_i(sys_clk), .rd_data_i(rd_data), .wr_stb_o(wr_stb), .rd_stb_o(rd_stb),
    .cmd_o(cmd), .wr_data_o(wr_data), .alert_clr_o(alert_clr));
  sfs_startup_fault_softoff #(.REF_W(16), .MS_CYC(8), .INT_DLY_CYC(2)) DUT (.sys_clk_i(sys_clk),
    .rst_n_i(rst_n), .wr_stb_i(wr_stb), .rd_stb_i(rd_stb), .cmd_i(cmd), .wr_data_i(wr_data),
    .rd_data_o(rd_data), .alert_o(alert), .alert_clr_i(alert_clr), .run_cmd_i(run), .vout_target_i(vtgt),
    .vout_sense_i(vsense), .tmax_enable_i(tmax_en), .tmax_limit_qms_i(16'h0004), .rise_qms_i(16'h0004),
    .vout_in_band_i(inband), .detail_vout_i(dvout), .detail_output_overvoltage_summary_i(dov), .detail_other_sum_i(dother),
    .timeout_event_o(tev), .convert_o(conv), .ref_dac_o(dac), .cml_event_o(cml));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Whether a setting write lies inside the supported range
  function automatic logic accepts(input logic [7:0] c, input logic [15:0] v);
    if (c == 8'h63)
      return v[7:6] != 2'h3;
    if (c == 8'h64)
      return v[15:11] == 5'h1F && v[10:0] <= 11'h0FF;
    return v[15:11] == 5'h1E && v[10:0] <= 11'h07F;
  endfunction
  // Cycles from the timeout pulse to shutdown, 8 cycles per ms here
  function automatic int exp_gap(input logic [7:0] v);
    if (v[7:6] == 2'h0)
      return 300;
    if (v[7:6] == 2'h2)
      return 0;
    return ((v[2:0] == 3'h0) ? 1 : int'(v[2:0])) * 8 - 1;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Restart attempts show up as rising edges of the power stage
  always @(posedge conv)
    rises++;
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end
  initial
  begin
    {rst_n, run, tmax_en, dov} = 4'h0;
    dvout = 8'h00;
    vsense = 16'h0000;
    inband = 1'b0;
    dother = 5'h00;
    vtgt = 16'h4000;
    r = 32'h00013DF8;
    shadow = '{16'hF800, 16'hF002, 16'h0000, 16'h0000};
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    for (i = 0; i < 3; i++)
    begin
      host.put(8'h64 + 8'(i), 16'h0000, 1'b1);
      check(host.last_q, shadow[i]);
    end
    // Corner writes first, then random settings, each read back
    for (i = 0; i < 28; i++)
    begin
      r = lfsr(r);
      k = int'(r[9:8]) % 3;
      d = r[31:16];
      if (r[10])
        d[15:11] = (k == 1) ? 5'h1F : 5'h1E;
      if (r[11])
        d[10:8] = 3'h0;
      cd = (i < 4) ? corner[i] : {8'h63 + 8'(k), d};
      ok = accepts(cd[23:16], cd[15:0]);
      host.put(cd[23:16], cd[15:0], 1'b0);
      if (ok)
        shadow[cd[17:16]] = (cd[23:16] == 8'h63) ? {8'h00, cd[7:0]} : cd[15:0];
      check({15'h0, alert}, {15'h0, !ok});
      host.put(cd[23:16], 16'h0000, 1'b1);
      check(host.last_q, shadow[cd[17:16]]);
      host.clr();
    end
    // Summary follows the detailed flags
    dov = 1'b1;
    dvout = 8'h04;
    dother = 5'h14;
    repeat (2) @(negedge sys_clk);
    host.put(8'h78, 16'h0000, 1'b1);
    q = host.last_q;
    check(q, 16'h0074);
    host.put(8'h79, 16'h0000, 1'b1);
    check(host.last_q, {8'h80, q[7:0]});
    check({15'h0, q[5]}, 16'h0001);
    {dov, dvout, dother} = 14'h0000;
    repeat (2) @(negedge sys_clk);
    host.put(8'h78, 16'h0000, 1'b1);
    check({15'h0, host.last_q[5]}, 16'h0000);
    // Start timeout responses, six entries over the three actions and restart counts 0, 2, 6 and 7
    tmax_en = 1'b1;
    host.put(8'h64, 16'hF800, 1'b0);
    host.put(8'h65, 16'hF002, 1'b0);
    for (i = 0; i < 6; i++)
    begin
      r = lfsr(r);
      a = acts[i] | ((i == 1) ? {5'h00, r[2:0]} : 8'h00);
      host.put(8'h63, {8'h00, a}, 1'b0);
      run = 1'b1;
      for (n = 0; tev !== 1'b1 && n < 300; n++)
        @(negedge sys_clk);
      for (n = 0; conv === 1'b1 && n < 300; n++)
        @(negedge sys_clk);
      m = rises;
      repeat (300) @(negedge sys_clk);
      m = rises - m;
      e = exp_gap(a);
      check({15'h0, n >= e - 3 && n <= e + 3}, 16'h0001);
      e = (a[7:6] == 2'h0) ? 0 : int'(a[5:3]);
      check({15'h0, (e == 7) ? m > 6 : m == e}, 16'h0001);
      host.put(8'h78, 16'h0000, 1'b1);
      check({15'h0, host.last_q[0] & alert}, 16'h0001);
      run = 1'b0;
      repeat (40) @(negedge sys_clk);
      host.clr();
    end
    // Soft-off timing, shortest fall first
    tmax_en = 1'b0;
    for (i = 0; i < 2; i++)
    begin
      r = lfsr(r);
      vtgt = r[31:16] | 16'h1000;
      d = (i == 0) ? 16'h0001 : {1'b0, r[14:8], 2'h0, r[5:0]};
      host.put(8'h64, 16'hF800 | {10'h000, d[5:0]}, 1'b0);
      host.put(8'h65, 16'hF000 | {9'h000, d[14:8]}, 1'b0);
      // Second pass reaches regulation so the stop starts from the on state
      vsense = (i == 1) ? vtgt : 16'h0000;
      inband = (i == 1);
      run = 1'b1;
      repeat (30) @(negedge sys_clk);
      check({15'h0, conv}, 16'h0001);
      check(dac, vtgt);
      run = 1'b0;
      for (n = 0; conv === 1'b1 && n < 2000; n++)
        @(negedge sys_clk);
      e = int'(d[5:0]) * 4 + ((d[14:8] < 7'h02) ? 2 : int'(d[14:8])) * 2;
      check({15'h0, n >= e && n <= e + 4}, 16'h0001);
      check(dac, 16'h0000);
    end
    complete_run();
  end
endmodule
`default_nettype wire
